// file: logic/qenc_core.v
`timescale 1ns/1ps
`include "qenc_defines.vh"
// How it works
// [RL1] position and velocity have own enables; velocity runs only with position enabled
// [RL2] swap exchanges phase a and phase b ahead of all decoding
// [RL3] signal mode zero decodes quadrature, one decodes clock/direction
// [RL4] clock/direction: phase a steps, phase b gives direction
// [RL5] quadrature edge capture picks phase-a-only or both-phase counting
// [RL6] capture select zero counts phase a edges, one counts both
// [RL7] phase a leading phase b increments the position
// [RL8] phase b leading phase a decrements the position
// [RL9] rise and fall on one phase with no other-phase edge flags direction change
// [RL10] reset select one clears position on index pulse
// [RL11] decrement below zero loads the programmed maximum
// [RL12] software programs maximum as counted edges per revolution minus one
// [RL13] position is absolute only after the first index pulse is seen
// [RL14] reset select zero ignores index and wraps past maximum to zero
// [RL15] velocity counts the same edges the position counter sees
// [RL16] at period end accumulator copies to result, then restarts at zero, or at one if a counted edge lands on expiry
// [RL17] timer counts down from load, expires at zero, reloads and continues
// [RL18] prescale code n divides velocity edges by two to the n
// [RL19] events raised for phase error, direction change, index, timer expiry
// [RL20] each event has mask, raw status, masked status and clear
// [RL21] software configures mode and maximum before setting enable
// [RL22] both phases changing in one quadrature sample is an error, no count
// [RL23] phase and index inputs are synchronised and edge detected
module qenc_core #(
	parameter POS_W = 32,
	parameter VEL_W = 32
) (
	input wire i_ref_clk,
	input wire i_reset_n,
	input wire i_clk_en,
	input wire i_phase_a_input,
	input wire i_phase_b_input,
	input wire i_index_input,
	input wire i_encoder_enable,
	input wire i_velocity_enable,
	input wire i_swap_select,
	input wire i_signal_mode_select,
	input wire i_edge_capture_select,
	input wire i_position_reset_select,
	input wire [2:0] i_velocity_prescale,
	input wire [POS_W-1:0] i_max_position,
	input wire [VEL_W-1:0] i_velocity_period_load,
	input wire i_position_wr,
	input wire [POS_W-1:0] i_position_wdata,
	input wire [`QENC_INT_W-1:0] i_int_mask,
	input wire [`QENC_INT_W-1:0] i_int_clear,
	output reg [POS_W-1:0] o_position,
	output reg [VEL_W-1:0] o_velocity_result,
	output reg [VEL_W-1:0] o_velocity_accumulator,
	output reg [VEL_W-1:0] o_velocity_timer,
	output reg o_direction,
	output reg o_phase_error,
	output reg o_index_seen,
	output reg [`QENC_INT_W-1:0] o_int_raw,
	output wire [`QENC_INT_W-1:0] o_int_masked
);

	reg [2:0] sync1_r;
	reg [2:0] sync2_r;
	reg [2:0] prev_r;
	reg [1:0] last_edge_r;
	reg last_dir_src_r;
	reg [6:0] prediv_r;

	wire vel_run;
	wire phase_a_input;
	wire phase_b_input;
	wire pha_p;
	wire phb_p;
	wire idx_rise;
	wire a_edge;
	wire b_edge;
	wire both_edge;
	reg step;
	reg up;
	reg dir_chg;
	reg [`QENC_INT_W-1:0] ev;
	reg [POS_W-1:0] pos_nxt;
	reg prediv_tick;
	reg [6:0] prediv_lim;
	wire track_edge;

	// plain mux, shared by the current and the previous sample
	function phase_pick;
		input swap;
		input own;
		input other;
		begin
			phase_pick = swap ? other : own;
		end
	endfunction

	// one step up or down; wrap handling stays with the caller
	function [POS_W-1:0] pos_step;
		input [POS_W-1:0] cur;
		input inc;
		begin
			if (inc)
				pos_step = cur + {{(POS_W-1){1'b0}}, 1'b1};
			else
				pos_step = cur - {{(POS_W-1){1'b0}}, 1'b1};
		end
	endfunction

	assign vel_run = i_encoder_enable & i_velocity_enable; // [RL1]
	assign phase_a_input = phase_pick(i_swap_select, sync2_r[0], sync2_r[1]); // [RL2]
	assign phase_b_input = phase_pick(i_swap_select, sync2_r[1], sync2_r[0]); // [RL2]
	assign pha_p = phase_pick(i_swap_select, prev_r[0], prev_r[1]); // [RL2]
	assign phb_p = phase_pick(i_swap_select, prev_r[1], prev_r[0]); // [RL2]
	assign track_edge = ~i_signal_mode_select & ~both_edge & (a_edge | b_edge);
	assign idx_rise = sync2_r[2] & ~prev_r[2]; // [RL23]
	assign a_edge = phase_a_input ^ pha_p; // [RL23]
	assign b_edge = phase_b_input ^ phb_p;
	assign both_edge = a_edge & b_edge;
	assign o_int_masked = o_int_raw & i_int_mask; // [RL20]

	// decode step and direction for one sample
	always @* begin
		step = 1'b0;
		up = 1'b0;
		dir_chg = 1'b0;
		if (i_signal_mode_select) begin // [RL3]
			step = phase_a_input & ~pha_p; // [RL4]
			up = ~phase_b_input; // [RL4]
		end else if (!both_edge) begin // [RL22]
			// a leads b: a changes to differ from b, b changes to equal a
			if (a_edge) begin
				step = 1'b1; // [RL5] [RL6]
				up = (phase_a_input != phase_b_input); // [RL7] [RL8]
			end else if (b_edge) begin
				step = i_edge_capture_select; // [RL5] [RL6]
				up = (phase_a_input == phase_b_input); // [RL7] [RL8]
			end
			// same phase toggled twice with nothing between means reversal
			if ((a_edge && last_edge_r == 2'h1 && !last_dir_src_r) ||
			    (b_edge && last_edge_r == 2'h1 && last_dir_src_r))
				dir_chg = 1'b1; // [RL9]
		end
	end

	always @* begin
		pos_nxt = o_position;
		if (i_position_reset_select && idx_rise) begin
			pos_nxt = {POS_W{1'b0}}; // [RL10] [RL13]
		end else if (step && up) begin
			if (!i_position_reset_select && o_position >= i_max_position)
				pos_nxt = {POS_W{1'b0}}; // [RL14]
			else
				pos_nxt = pos_step(o_position, 1'b1); // [RL7]
		end else if (step) begin
			if (o_position == {POS_W{1'b0}})
				pos_nxt = i_max_position; // [RL11]
			else
				pos_nxt = pos_step(o_position, 1'b0); // [RL8]
		end
	end

	always @* begin
		prediv_lim = 7'h00;
		case (i_velocity_prescale)
		3'h0: prediv_lim = 7'h00;
		3'h1: prediv_lim = 7'h01;
		3'h2: prediv_lim = 7'h03;
		3'h3: prediv_lim = 7'h07;
		3'h4: prediv_lim = 7'h0F;
		3'h5: prediv_lim = 7'h1F;
		3'h6: prediv_lim = 7'h3F;
		default: prediv_lim = 7'h7F;
		endcase
		prediv_tick = step && (prediv_r >= prediv_lim); // [RL18] [RL15]
	end

	always @* begin
		ev = {`QENC_INT_W{1'b0}};
		ev[`QENC_INT_PHERR] = i_encoder_enable & ~i_signal_mode_select & both_edge; // [RL22]
		ev[`QENC_INT_DIR] = i_encoder_enable & dir_chg; // [RL19]
		ev[`QENC_INT_INDEX] = i_encoder_enable & idx_rise; // [RL19]
		ev[`QENC_INT_TIMER] = vel_run && (o_velocity_timer == {VEL_W{1'b0}}); // [RL17]
	end

	// two-stage synchroniser; stage one feeds stage two only
	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
			prev_r <= 3'h0;
		end else if (i_clk_en) begin
			sync1_r <= {i_index_input, i_phase_b_input, i_phase_a_input}; // [RL23]
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	// software load wins over counting in the same cycle
	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_position <= `QENC_POS_RESET;
		end else if (i_clk_en) begin
			if (i_position_wr)
				o_position <= i_position_wdata;
			else if (i_encoder_enable)
				o_position <= pos_nxt; // [RL10] [RL14]
		end
	end

	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_direction <= 1'b0;
			o_phase_error <= 1'b0;
			o_index_seen <= 1'b0;
		end else if (i_clk_en) begin
			if (!i_encoder_enable) begin
				// cleared while off so a restart waits for a fresh index
				o_index_seen <= 1'b0;
				o_phase_error <= 1'b0;
			end else begin
				if (step)
					o_direction <= ~up;
				if (ev[`QENC_INT_PHERR])
					o_phase_error <= 1'b1; // [RL22]
				if (idx_rise)
					o_index_seen <= 1'b1; // [RL13]
			end
		end
	end

	// remembers which phase moved last; a repeat on the same phase is a reversal
	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			last_edge_r <= 2'h0;
			last_dir_src_r <= 1'b0;
		end else if (i_clk_en) begin
			if (i_encoder_enable && track_edge) begin
				last_edge_r <= 2'h1; // [RL9]
				last_dir_src_r <= b_edge;
			end
		end
	end

	// timer sits at the load value while velocity capture is off
	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_velocity_timer <= `QENC_VEL_RESET;
		end else if (i_clk_en) begin
			if (!vel_run || ev[`QENC_INT_TIMER])
				o_velocity_timer <= i_velocity_period_load; // [RL1] [RL17]
			else
				o_velocity_timer <= o_velocity_timer - {{(VEL_W-1){1'b0}}, 1'b1}; // [RL17]
		end
	end

	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_velocity_result <= `QENC_VEL_RESET;
			o_velocity_accumulator <= `QENC_VEL_RESET;
			prediv_r <= 7'h00;
		end else if (i_clk_en) begin
			if (!vel_run) begin // [RL1]
				o_velocity_accumulator <= {VEL_W{1'b0}};
				prediv_r <= 7'h00;
			end else begin
				if (step)
					prediv_r <= prediv_tick ? 7'h00 : prediv_r + 7'h01; // [RL18]
				if (ev[`QENC_INT_TIMER]) begin
					// the edge landing on expiry opens the next period
					o_velocity_result <= o_velocity_accumulator; // [RL16]
					o_velocity_accumulator <= {{(VEL_W-1){1'b0}}, prediv_tick}; // [RL16]
				end else if (prediv_tick) begin
					o_velocity_accumulator <= o_velocity_accumulator +
						{{(VEL_W-1){1'b0}}, 1'b1}; // [RL15]
				end
			end
		end
	end

	// set wins over clear for every sticky event bit
	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_int_raw <= {`QENC_INT_W{1'b0}};
		end else if (i_clk_en) begin
			o_int_raw <= (o_int_raw & ~i_int_clear) | ev; // [RL19] [RL20]
		end
	end

endmodule

// file: include/qenc_defines.vh
`ifndef QENC_DEFINES_VH
`define QENC_DEFINES_VH
`define QENC_POS_RESET 32'h00000000
`define QENC_VEL_RESET 32'h00000000
`define QENC_PRESCALE_MAX 3'h7
`define QENC_INT_PHERR 0
`define QENC_INT_DIR 1
`define QENC_INT_INDEX 2
`define QENC_INT_TIMER 3
`define QENC_INT_W 4
`endif

// file: sim/qenc_props.sv
`timescale 1ns/1ps
module qenc_props #(parameter POS_W = 32, parameter VEL_W = 32) (
	input wire i_ref_clk,
	input wire i_reset_n,
	input wire i_clk_en,
	input wire i_encoder_enable,
	input wire i_velocity_enable,
	input wire i_position_reset_select,
	input wire i_position_wr,
	input wire [POS_W-1:0] i_max_position,
	input wire [VEL_W-1:0] i_velocity_period_load,
	input wire [3:0] i_int_mask,
	input wire [3:0] i_int_clear,
	input wire [POS_W-1:0] o_position,
	input wire [VEL_W-1:0] o_velocity_result,
	input wire [VEL_W-1:0] o_velocity_accumulator,
	input wire [VEL_W-1:0] o_velocity_timer,
	input wire [3:0] o_int_raw,
	input wire [3:0] o_int_masked
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	wire run = i_clk_en && i_encoder_enable;
	wire vrun = run && i_velocity_enable;
	wire tz = vrun && o_velocity_timer == 0;
	a_masked_view: assert property (o_int_masked == (o_int_raw & i_int_mask))
		else $error("masked bits");
	a_raw_sticky: assert property
		(($past(o_int_raw) & ~$past(i_int_clear) & ~o_int_raw) == 4'h0) else $error("raw lost");
	a_pos_hold: assert property (i_clk_en && !i_encoder_enable && !i_position_wr
		|=> $stable(o_position)) else $error("counted while off");
	a_vel_off: assert property (i_clk_en && !vrun |=> o_velocity_accumulator == 0
		&& o_velocity_timer == $past(i_velocity_period_load)) else $error("velocity ran");
	a_timer_step: assert property (vrun && o_velocity_timer != 0
		|=> o_velocity_timer == $past(o_velocity_timer) - 1) else $error("timer step");
	a_timer_reload: assert property (tz |=> o_int_raw[3]
		&& o_velocity_timer == $past(i_velocity_period_load)) else $error("timer reload");
	a_result_copy: assert property (tz
		|=> o_velocity_result == $past(o_velocity_accumulator)) else $error("result copy");
	// only from inside the range: a software load may sit above the maximum
	a_pos_range: assert property (run && !i_position_wr && !i_position_reset_select
		&& o_position <= i_max_position |=> o_position <= $past(i_max_position))
		else $error("position range");
endmodule
bind qenc_core qenc_props #(.POS_W(POS_W), .VEL_W(VEL_W)) qenc_props_i (.*);

// file: sim/qenc_enc_model.sv
`timescale 1ns/1ps
module qenc_enc_model (input wire i_ref_clk, output reg o_a = 1'b0, output reg o_b = 1'b0);
	// gray steps, a leads b going up; 4 clocks a level beats the 2-flop sync
	task step(input fwd, input both);
		@(negedge i_ref_clk);
		{o_a, o_b} = {o_a, o_b} ^ (both ? 2'h3 : (o_a ^ o_b ^ fwd) ? 2'h2 : 2'h1);
		repeat (3) @(negedge i_ref_clk);
	endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	reg clk = 1'b0, rst_n = 1'b0, en = 1'b0, ven = 1'b0, swp = 1'b0, sm = 1'b0, cap = 1'b0;
	reg rs = 1'b0, wr = 1'b0, x = 1'b0, f, ce = 1'b1;
	wire dir, perr;
	reg [2:0] pre = 3'h0;
	reg [3:0] clr = 4'h0;
	reg [31:0] mx = 32'h3E8, ld = 32'hFFFF, wd = 32'h0, acc0;
	wire a, b, iseen;
	wire [3:0] raw;
	wire [31:0] pos, vres, vacc;
	integer error_cnt = 0, num_checks = 0, i, j;
	reg [10:0] rows [0:5] = '{11'h102, 11'h304, 11'h2FC, 11'h7FC, 11'h402, 11'h0FE};
	qenc_core qenc_core_i (.i_ref_clk(clk), .i_reset_n(rst_n), .i_clk_en(ce),
		.i_phase_a_input(a), .i_phase_b_input(b), .i_index_input(x), .i_encoder_enable(en),
		.i_velocity_enable(ven), .i_swap_select(swp), .i_signal_mode_select(sm),
		.i_edge_capture_select(cap), .i_position_reset_select(rs), .i_velocity_prescale(pre),
		.i_max_position(mx), .i_velocity_period_load(ld), .i_position_wr(wr),
		.i_position_wdata(wd), .i_int_mask(4'hF), .i_int_clear(clr), .o_position(pos),
		.o_velocity_result(vres), .o_velocity_accumulator(vacc), .o_velocity_timer(),
		.o_direction(dir), .o_phase_error(perr), .o_index_seen(iseen), .o_int_raw(raw),
		.o_int_masked());
	qenc_enc_model qenc_enc_model_i (.i_ref_clk(clk), .o_a(a), .o_b(b));
	task chk(input [31:0] got, input [31:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("mismatch %0t %h %h", $time, got, exp);
		end
	endtask
	task summarize;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task w(input integer n);
		repeat (n) @(negedge clk);
	endtask
	// settle first: a swap or mode change can look like an edge
	task setpos(input [31:0] v);
		w(4);
		wd = v;
		wr = 1'b1;
		w(1);
		wr = 1'b0;
	endtask
	task steps(input fw, input both, input integer n);
		repeat (n) qenc_enc_model_i.step(fw, both);
		w(2);
	endtask
	task clear;
		clr = 4'hF;
		w(1);
		clr = 4'h0;
	endtask
	initial forever #2.5 clk = ~clk;
	initial begin
		w(20);
		chk(pos, 32'h0);
		rst_n = 1'b1;
		w(3);
		en = 1'b1;
		ven = 1'b1;
		for (i = 0; i < 6; i = i + 1) begin
			{swp, cap, f} = rows[i][10:8];
			setpos(32'h64);
			acc0 = vacc;
			steps(f, 1'b0, 4);
			chk(pos, 32'h64 + {{24{rows[i][7]}}, rows[i][7:0]});
			chk(vacc - acc0, cap ? 32'h4 : 32'h2);
		end
		sm = 1'b1;
		setpos(32'h64);
		for (i = 0; i < 4; i = i + 1) steps(~i[0], 1'b0, 1);
		chk(pos > 32'h64, 1'b1);
		sm = 1'b0;
		cap = 1'b1;
		setpos(32'h0);
		steps(1'b0, 1'b0, 1);
		chk(pos, mx);
		setpos(mx);
		steps(1'b1, 1'b0, 1);
		chk(pos, 32'h0);
		rs = 1'b1;
		setpos(32'h32);
		chk(iseen, 1'b0);
		x = 1'b1;
		w(3);
		x = 1'b0;
		w(4);
		chk(pos, 32'h0);
		chk(iseen, 1'b1);
		clear;
		steps(1'b0, 1'b1, 1);
		chk(raw[0], 1'b1);
		chk(perr, 1'b1);
		chk(pos, 32'h0);
		clear;
		steps(1'b1, 1'b0, 1);
		steps(1'b0, 1'b0, 1);
		chk(raw[1:0], 2'h2);
		chk(dir, 1'b1);
		ce = 1'b0; // pin moves while frozen; the count lands after release
		steps(1'b1, 1'b0, 1);
		chk(pos, 32'h0);
		ce = 1'b1;
		w(4);
		chk(pos, 32'h1);
		ld = 32'h3C;
		for (i = 0; i < 4; i = i + 1) begin
			ven = 1'b0;
			pre = i[2:0];
			clear;
			ven = 1'b1;
			steps(1'b1, 1'b0, 8);
			for (j = 0; j < 300 && raw[3] !== 1'b1; j = j + 1) w(1);
			chk(j < 300, 1'b1);
			if (j == 300) summarize;
			chk(vres, 32'h8 >> i);
		end
		summarize;
	end
endmodule
